// file: fc_flash_host.sv
`timescale 1ns/1ps
`include "fc_flash_cfg.svh"

module fc_flash_host #(
  parameter int unsigned POLL_LIMIT = `FC_T_EC_MS * `FC_CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // User command port
  input wire logic req_valid,
  input wire fc_pkg::fc_req_s req,
  input wire logic abort_req,
  input wire logic boot_override,
  output fc_pkg::fc_rsp_s rsp,
  // Flash pins
  output logic [16:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_b,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic flash_rst_b,
  output logic flash_hv_en
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WADDR = 4'h1,
    ST_WLOW = 4'h3,
    ST_WHIGH = 4'h2,
    ST_RLOW = 4'h6,
    ST_RCAP = 4'h7,
    ST_DONE = 4'h5,
    ST_RESET = 4'h4
  } fc_state_e;

  fc_state_e state_r;
  fc_pkg::fc_req_s req_r;
  logic [2:0] step_r;
  logic [7:0] cnt_r;
  logic [31:0] poll_cnt_r;
  logic [7:0] rd_r;
  logic prev_tog_r;
  logic have_prev_r;
  logic polling_r;

  // Command table: address and byte for each step of each sequence
  function automatic fc_pkg::fc_word_s seq_word(input fc_pkg::fc_op_e op, input logic [2:0] step,
                                                input logic [16:0] addr, input logic [7:0] data);
    fc_pkg::fc_word_s w;
    w = '{addr: `FC_CMD_ADDR_A, data: `FC_CMD_UNLOCK1};
    unique case (step)
      3'h1: w = '{addr: `FC_CMD_ADDR_B, data: `FC_CMD_UNLOCK2};
      3'h2:
      begin
        unique case (op)
          fc_pkg::FC_OP_PROG: w.data = `FC_CMD_PROG;
          fc_pkg::FC_OP_ID_ENTRY: w.data = `FC_CMD_ID_IN;
          fc_pkg::FC_OP_ID_EXIT: w.data = `FC_CMD_ID_OUT;
          default: w.data = `FC_CMD_SETUP;
        endcase
      end
      3'h3: w = (op == fc_pkg::FC_OP_PROG) ? '{addr: addr, data: data} : w;
      3'h4: w = '{addr: `FC_CMD_ADDR_B, data: `FC_CMD_UNLOCK2};
      3'h5:
      begin
        unique case (op)
          fc_pkg::FC_OP_SECTOR_ERASE: w = '{addr: addr, data: `FC_CMD_SECTOR};
          fc_pkg::FC_OP_LOCKOUT: w.data = `FC_CMD_LOCK;
          default: w.data = `FC_CMD_CHIP;
        endcase
      end
      default: w = '{addr: `FC_CMD_ADDR_A, data: `FC_CMD_UNLOCK1};
    endcase
    return w;
  endfunction : seq_word

  // Number of bus cycles in each sequence
  function automatic logic [2:0] seq_len(input fc_pkg::fc_op_e op);
    unique case (op)
      fc_pkg::FC_OP_PROG: seq_len = `FC_LEN_PROG;
      fc_pkg::FC_OP_ID_ENTRY, fc_pkg::FC_OP_ID_EXIT: seq_len = `FC_LEN_ID;
      default: seq_len = `FC_LEN_SIX;
    endcase
  endfunction : seq_len

  fc_pkg::fc_word_s next_word;
  fc_pkg::fc_word_s first_word;
  logic last_step;
  logic needs_poll;
  logic toggle_stable;

  // Step decode shared by the sequencer
  always_comb
  begin
    first_word = seq_word(req.op, 3'h0, req.addr, req.data);
    next_word = seq_word(req_r.op, step_r + 3'h1, req_r.addr, req_r.data);
    last_step = (step_r == seq_len(req_r.op) - 3'h1);
    needs_poll = (req_r.op != fc_pkg::FC_OP_ID_ENTRY) && (req_r.op != fc_pkg::FC_OP_ID_EXIT);
    toggle_stable = have_prev_r && (rd_r[`FC_TOGGLE_BIT] == prev_tog_r);
  end

  // Sequencer and pin drive; every pin is a flop so no glitch reaches the flash
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_r <= ST_RESET;
      step_r <= 3'h0;
      cnt_r <= 8'h00;
      req_r <= '0;
      flash_addr <= 17'h00000;
      flash_dq_out <= 8'h00;
      flash_dq_oe_b <= 1'b1;
      flash_ce_b <= 1'b1;
      flash_oe_b <= 1'b1;
      flash_we_b <= 1'b1;
      flash_rst_b <= 1'b0;
      flash_hv_en <= 1'b0;
    end
    else if (abort_req && state_r != ST_RESET)
    begin
      // Abort pulses the flash reset; the cut operation is reported for reissue
      state_r <= ST_RESET;
      cnt_r <= 8'h00;
      flash_rst_b <= 1'b0;
      flash_dq_oe_b <= 1'b1;
      flash_ce_b <= 1'b1;
      flash_oe_b <= 1'b1;
      flash_we_b <= 1'b1;
      flash_hv_en <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            req_r <= req;
            step_r <= 3'h0;
            cnt_r <= 8'h00;
            flash_ce_b <= 1'b0;
            flash_hv_en <= boot_override;
            if (req.op == fc_pkg::FC_OP_READ)
            begin
              flash_addr <= req.addr;
              flash_oe_b <= 1'b0;
              state_r <= ST_RLOW;
            end
            else
            begin
              flash_addr <= first_word.addr;
              flash_dq_out <= first_word.data;
              flash_dq_oe_b <= 1'b0;
              state_r <= ST_WADDR;
            end
          end
        end
        ST_WADDR:
        begin
          // Address settles a cycle before the strobe falls
          flash_we_b <= 1'b0;
          state_r <= ST_WLOW;
        end
        ST_WLOW:
        begin
          if (cnt_r == 8'(`FC_WP_CYC - 1))
          begin
            flash_we_b <= 1'b1;
            flash_ce_b <= 1'b1;
            state_r <= ST_WHIGH;
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_WHIGH:
        begin
          // Data held through the rising strobe, released a cycle later
          cnt_r <= 8'h00;
          if (!last_step)
          begin
            step_r <= step_r + 3'h1;
            flash_addr <= next_word.addr;
            flash_dq_out <= next_word.data;
            flash_ce_b <= 1'b0;
            state_r <= ST_WADDR;
          end
          else if (needs_poll)
          begin
            flash_dq_oe_b <= 1'b1;
            flash_ce_b <= 1'b0;
            flash_oe_b <= 1'b0;
            state_r <= ST_RLOW;
          end
          else
          begin
            flash_dq_oe_b <= 1'b1;
            state_r <= ST_DONE;
          end
        end
        ST_RLOW:
        begin
          if (cnt_r == 8'(`FC_ACC_CYC - 1))
          begin
            flash_ce_b <= 1'b1;
            flash_oe_b <= 1'b1;
            state_r <= ST_RCAP;
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_RCAP:
        begin
          cnt_r <= 8'h00;
          // Two reads with the same toggle flag mean the operation ended
          if (!polling_r || toggle_stable || poll_cnt_r >= POLL_LIMIT)
          begin
            state_r <= ST_DONE;
          end
          else
          begin
            flash_ce_b <= 1'b0;
            flash_oe_b <= 1'b0;
            state_r <= ST_RLOW;
          end
        end
        ST_DONE:
        begin
          flash_hv_en <= 1'b0;
          state_r <= ST_IDLE;
        end
        ST_RESET:
        begin
          // Reset low, then recovery before the first cycle to the flash
          flash_rst_b <= (cnt_r >= 8'(`FC_RST_CYC - 1));
          if (cnt_r == 8'(`FC_RST_CYC + `FC_RREC_CYC - 1))
          begin
            state_r <= ST_IDLE;
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      endcase
    end
  end

  // Status polling: captured byte, previous toggle flag, time spent
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rd_r <= 8'h00;
      prev_tog_r <= 1'b0;
      have_prev_r <= 1'b0;
      polling_r <= 1'b0;
      poll_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      if (state_r == ST_RLOW && cnt_r == 8'(`FC_ACC_CYC - 1))
      begin
        rd_r <= flash_dq_in;
      end
      if (state_r == ST_IDLE)
      begin
        polling_r <= 1'b0;
        have_prev_r <= 1'b0;
        poll_cnt_r <= 32'h0000_0000;
      end
      else if (state_r == ST_WHIGH && last_step)
      begin
        polling_r <= needs_poll;
      end
      else if (state_r == ST_RCAP)
      begin
        prev_tog_r <= rd_r[`FC_TOGGLE_BIT];
        have_prev_r <= 1'b1;
      end
      // Saturating limit guards against a flash that never settles; idle must win so counts never carry over
      if (polling_r && state_r != ST_IDLE && poll_cnt_r != 32'hffff_ffff)
      begin
        poll_cnt_r <= poll_cnt_r + 32'h0000_0001;
      end
    end
  end

  // User response
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rsp <= '{busy: 1'b1, done: 1'b0, aborted: 1'b0, timeout: 1'b0, rdata: 8'h00};
    end
    else
    begin
      rsp.done <= 1'b0;
      if (abort_req && state_r != ST_RESET)
      begin
        rsp.busy <= 1'b1;
        rsp.aborted <= (state_r != ST_IDLE);
      end
      else if (state_r == ST_IDLE && req_valid)
      begin
        rsp.busy <= 1'b1;
        rsp.aborted <= 1'b0;
        rsp.timeout <= 1'b0;
      end
      else if (state_r == ST_RCAP && polling_r && !toggle_stable && poll_cnt_r >= POLL_LIMIT)
      begin
        rsp.timeout <= 1'b1;
      end
      else if (state_r == ST_DONE)
      begin
        rsp.done <= 1'b1;
        rsp.busy <= 1'b0;
        rsp.rdata <= rd_r;
      end
      else if (state_r == ST_RESET && cnt_r == 8'(`FC_RST_CYC + `FC_RREC_CYC - 1))
      begin
        rsp.busy <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  chk_write_strobe_form: assert property (!flash_we_b |-> flash_oe_b && !flash_ce_b && !flash_dq_oe_b)
    else $error("write strobe low without chip select low, output drive high and data driven");
  chk_strobe_width: assert property ($fell(flash_we_b) |-> (!flash_we_b)[*2] ##1 flash_we_b)
    else $error("write strobe width is not two cycles");
  chk_first_cycle_cmd: assert property ($fell(flash_we_b) && step_r == 3'h0
                                        |-> flash_addr == `FC_CMD_ADDR_A && flash_dq_out == `FC_CMD_UNLOCK1)
    else $error("first command cycle has wrong address or data");
  chk_six_cycle_erase: assert property (state_r == ST_WHIGH && last_step && req_r.op == fc_pkg::FC_OP_CHIP_ERASE
                                        |-> step_r == 3'h5 && $past(flash_dq_out) == `FC_CMD_CHIP)
    else $error("chip erase sequence is not six cycles ending in the erase byte");
  chk_prog_four_cycles: assert property (state_r == ST_WHIGH && last_step && req_r.op == fc_pkg::FC_OP_PROG
                                         |-> step_r == 3'h3 && flash_addr == req_r.addr
                                         && flash_dq_out == req_r.data)
    else $error("byte program sequence is not four cycles ending in address and data");
  chk_abort_resets: assert property (abort_req && state_r != ST_RESET && state_r != ST_IDLE
                                     |=> !flash_rst_b && rsp.aborted ##1 !flash_rst_b)
    else $error("abort did not pulse flash reset and report the cut operation");
  chk_no_write_in_reset: assert property (!flash_rst_b |-> flash_we_b && flash_ce_b)
    else $error("flash strobed while held in reset");

  cov_prog_done: cover property (state_r == ST_DONE && req_r.op == fc_pkg::FC_OP_PROG && !rsp.timeout);
  cov_chip_erase_done: cover property (state_r == ST_DONE && req_r.op == fc_pkg::FC_OP_CHIP_ERASE);
  cov_abort_mid_op: cover property (abort_req && state_r == ST_RLOW && polling_r);
  cov_read_done: cover property (state_r == ST_DONE && req_r.op == fc_pkg::FC_OP_READ);

endmodule : fc_flash_host

// file: fc_flash_cfg.svh
`ifndef FC_FLASH_CFG_SVH
`define FC_FLASH_CFG_SVH

// Clock period of clk_sys
`define FC_CLK_NS 50

// Pin timing targets, in ns
`define FC_T_WP_NS 100
`define FC_T_ACC_NS 150
`define FC_T_RST_NS 500
`define FC_T_RREC_NS 1000

// Longest chip erase time, in ms
`define FC_T_EC_MS 10000

// Derived cycle counts; least times round up
`define FC_WP_CYC ((`FC_T_WP_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_ACC_CYC ((`FC_T_ACC_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_RST_CYC ((`FC_T_RST_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_RREC_CYC ((`FC_T_RREC_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_CYC_PER_MS (1000000 / `FC_CLK_NS)

// Command addresses and data bytes
`define FC_CMD_ADDR_A 17'h00555
`define FC_CMD_ADDR_B 17'h00aaa
`define FC_CMD_UNLOCK1 8'haa
`define FC_CMD_UNLOCK2 8'h55
`define FC_CMD_SETUP 8'h80
`define FC_CMD_PROG 8'ha0
`define FC_CMD_CHIP 8'h10
`define FC_CMD_SECTOR 8'h30
`define FC_CMD_LOCK 8'h40
`define FC_CMD_ID_IN 8'h90
`define FC_CMD_ID_OUT 8'hf0

// Sequence lengths and status bit position
`define FC_LEN_PROG 3'h4
`define FC_LEN_SIX 3'h6
`define FC_LEN_ID 3'h3
`define FC_TOGGLE_BIT 6

`endif

// file: fc_pkg.sv
package fc_pkg;

  typedef enum logic [2:0] {
    FC_OP_READ = 3'h0,
    FC_OP_PROG = 3'h1,
    FC_OP_CHIP_ERASE = 3'h2,
    FC_OP_SECTOR_ERASE = 3'h3,
    FC_OP_LOCKOUT = 3'h4,
    FC_OP_ID_ENTRY = 3'h5,
    FC_OP_ID_EXIT = 3'h6
  } fc_op_e;

  typedef struct packed {
    fc_op_e op;
    logic [16:0] addr;
    logic [7:0] data;
  } fc_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic aborted;
    logic timeout;
    logic [7:0] rdata;
  } fc_rsp_s;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } fc_word_s;

endpackage : fc_pkg

// file: fc_flash_model.sv
`timescale 1ns/1ps

module fc_flash_model #(
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 20000
) (
  // Controls, active low, and override request
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic rst_b,
  input wire logic hv,
  // Address and data
  input wire logic [16:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:131071];
  logic [7:0] pdat, last_q;
  logic [16:0] a_q, lo, hi;
  logic [2:0] step;
  logic lock, id_mode, tog, rd_on, wr_on;
  realtime busy_end;

  // Power-up lands in read mode with an erased, unlocked array
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    {step, lock, id_mode, tog, wr_on, pdat, last_q} = '0;
    busy_end = 0;
  end

  // Boot block is writable unless locked at normal levels
  function automatic logic can_write(input logic [16:0] a);
    can_write = !(lock && !hv && a < 17'h04000);
  endfunction : can_write

  // Erase a range, skip the locked boot block, then stay busy
  task automatic erase(input logic [16:0] l, input logic [16:0] h);
    for (int i = int'(l); i <= int'(h); i++) if (can_write(17'(i))) mem[i] = 8'hff;
    pdat = 8'hff;
    busy_end = $realtime + ERASE_NS;
  endtask : erase

  // Command decoder; the array is touched only by real operations
  task automatic run(input logic [16:0] a, input logic [7:0] d);
    logic ok;
    ok = (a[10:0] == 11'h555);
    if (step == 3'h0 && d == 8'hf0) id_mode = 1'b0;
    case (step)
      3'h0, 3'h4: step = (ok && d == 8'haa) ? step + 3'h1 : 3'h0;
      3'h1, 3'h5: step = (a[10:0] == 11'h2aa && d == 8'h55) ? step + 3'h1 : 3'h0;
      3'h2:
      begin
        step = !ok ? 3'h0 : d == 8'ha0 ? 3'h3 : d == 8'h80 ? 3'h4 : 3'h0;
        if (ok && d == 8'h90) id_mode = 1'b1;
        if (ok && d == 8'hf0) id_mode = 1'b0;
      end
      3'h3:
      begin
        if (can_write(a)) mem[a] = mem[a] & d;
        pdat = d;
        busy_end = $realtime + PROG_NS;
        step = 3'h0;
      end
      default:
      begin
        if (ok && d == 8'h10) erase(17'h0, 17'h1ffff);
        if (d == 8'h30) erase(lo, hi);
        if (ok && d == 8'h40) lock = 1'b1;
        step = 3'h0;
      end
    endcase
  endtask : run

  // Address is taken on the later falling edge of the two strobes
  always @(negedge ce_b or negedge we_b)
    if (!ce_b && !we_b && oe_b)
    begin
      a_q = addr;
      wr_on = 1'b1;
    end

  // Data on the first rising edge; sector address comes from that edge too
  always @(posedge ce_b or posedge we_b)
    if (wr_on)
    begin
      wr_on = 1'b0;
      lo = addr[16] ? 17'h10000 : addr[15] ? 17'h08000 : addr[14] ? {3'h1, addr[13], 13'h0} : 17'h0;
      hi = addr[16] ? 17'h1ffff : addr[15] ? 17'h0ffff : addr[14] ? lo + 17'h01fff : 17'h03fff;
      if ($realtime < busy_end) step = 3'h0;
      else if (rst_b) run(step == 3'h6 ? addr : a_q, wdata);
    end

  // Reset low cuts any operation; the lock survives it
  always @(rst_b)
    if (!rst_b)
    begin
      busy_end = 0;
      step = 3'h0;
    end

  // Each new read during an operation flips the toggle flag
  always @* rd_on = !ce_b && !oe_b && we_b && rst_b;
  always @(posedge rd_on) if ($realtime < busy_end) tog = ~tog;

  // Sampled often, since busy ends on time and not on a pin change
  always #5
    if (!rd_on) rdata = ~last_q;
    else
    begin
      if ($realtime < busy_end) rdata = {~pdat[7], tog, pdat[5:0]};
      else if (id_mode && addr[1:0] == 2'h2) rdata = {7'h0, lock};
      else rdata = mem[addr];
      last_q = rdata;
    end
endmodule : fc_flash_model

// file: fc_tb.sv
`timescale 1ns/1ps

module tb;
  logic clk_sys, rst_b, req_valid, abort_req, boot_override;
  fc_pkg::fc_req_s req;
  fc_pkg::fc_rsp_s rsp;
  logic [16:0] flash_addr;
  logic [7:0] flash_dq_out, flash_dq_in, dev_dq, got;
  logic flash_dq_oe_b, flash_ce_b, flash_oe_b, flash_we_b, flash_rst_b, flash_hv_en;
  int mismatches, checks, n_wr;

  fc_flash_host #(.POLL_LIMIT(2000)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .abort_req(abort_req), .boot_override(boot_override), .rsp(rsp), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_b(flash_dq_oe_b), .flash_dq_in(flash_dq_in),
    .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_rst_b(flash_rst_b),
    .flash_hv_en(flash_hv_en));
  fc_flash_model flash (.ce_b(flash_ce_b), .oe_b(flash_oe_b), .we_b(flash_we_b), .rst_b(flash_rst_b),
    .hv(flash_hv_en & flash_rst_b), .addr(flash_addr), .wdata(flash_dq_in), .rdata(dev_dq));

  // Host wins the data lines only while its enable is low
  assign flash_dq_in = flash_dq_oe_b ? dev_dq : flash_dq_out;

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Bounded wait for a response flag at the falling edge
  task automatic wait_flag(input bit want_done);
    int n;
    n = 0;
    while ((want_done ? rsp.done !== 1'b1 : rsp.busy !== 1'b0) && n < 4000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 4000) chk(8'h1, 8'h0);
    if (n >= 4000) test_done();
  endtask : wait_flag

  task automatic issue(input fc_pkg::fc_op_e o, input logic [16:0] a, input logic [7:0] d, input logic ov);
    wait_flag(1'b0);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{o, a, d};
    boot_override <= ov;
    n_wr = 0;
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask : issue

  task automatic op(input fc_pkg::fc_op_e o, input logic [16:0] a, input logic [7:0] d, input logic ov);
    issue(o, a, d, ov);
    wait_flag(1'b1);
    got = rsp.rdata;
  endtask : op

  // Completed write strobes, to count cycles per sequence
  always @(posedge flash_we_b) if (rst_b) n_wr++;

  // Write strobes only with chip select low, output drive high, data driven
  always @(negedge clk_sys) if (rst_b && flash_we_b === 1'b0) chk({7'h0, flash_ce_b | ~flash_oe_b | flash_dq_oe_b}, 8'h0);

  task automatic t_program;
    op(fc_pkg::FC_OP_CHIP_ERASE, 17'h0, 8'h0, 1'b0);
    chk(8'(n_wr), 8'h06);
    op(fc_pkg::FC_OP_PROG, 17'h01234, 8'h5a, 1'b0);
    chk(8'(n_wr), 8'h04);
    chk({7'h0, rsp.timeout}, 8'h0);
    op(fc_pkg::FC_OP_READ, 17'h01234, 8'h0, 1'b0);
    chk(got, 8'h5a);
    op(fc_pkg::FC_OP_PROG, 17'h01234, 8'hf0, 1'b0);
    op(fc_pkg::FC_OP_READ, 17'h01234, 8'h0, 1'b0);
    chk(got, 8'h50);
    op(fc_pkg::FC_OP_READ, 17'h00555, 8'h0, 1'b0);
    chk(got, 8'hff);
  endtask : t_program

  // Erase parameter block 1 only; a main block byte must survive
  task automatic t_sector;
    op(fc_pkg::FC_OP_PROG, 17'h05ffe, 8'h3c, 1'b0);
    op(fc_pkg::FC_OP_PROG, 17'h10000, 8'h11, 1'b0);
    op(fc_pkg::FC_OP_SECTOR_ERASE, 17'h04000, 8'h0, 1'b0);
    chk(8'(n_wr), 8'h06);
    op(fc_pkg::FC_OP_READ, 17'h05ffe, 8'h0, 1'b0);
    chk(got, 8'hff);
    op(fc_pkg::FC_OP_READ, 17'h10000, 8'h0, 1'b0);
    chk(got, 8'h11);
  endtask : t_sector

  task automatic t_lockout;
    op(fc_pkg::FC_OP_LOCKOUT, 17'h0, 8'h0, 1'b0);
    op(fc_pkg::FC_OP_PROG, 17'h00010, 8'h00, 1'b0);
    op(fc_pkg::FC_OP_READ, 17'h00010, 8'h0, 1'b0);
    chk(got, 8'hff);
    op(fc_pkg::FC_OP_ID_ENTRY, 17'h0, 8'h0, 1'b0);
    op(fc_pkg::FC_OP_READ, 17'h00002, 8'h0, 1'b0);
    chk({7'h0, got[0]}, 8'h01);
    op(fc_pkg::FC_OP_ID_EXIT, 17'h0, 8'h0, 1'b0);
    op(fc_pkg::FC_OP_PROG, 17'h00010, 8'h00, 1'b1);
    op(fc_pkg::FC_OP_READ, 17'h00010, 8'h0, 1'b0);
    chk(got, 8'h00);
    op(fc_pkg::FC_OP_CHIP_ERASE, 17'h0, 8'h0, 1'b0);
    op(fc_pkg::FC_OP_READ, 17'h00010, 8'h0, 1'b0);
    chk(got, 8'h00);
  endtask : t_lockout

  // Abort after n cycles: flash reset must pulse and the cut operation be reported
  task automatic cut_after(input int n);
    repeat (n) @(posedge clk_sys);
    abort_req <= 1'b1;
    @(posedge clk_sys);
    abort_req <= 1'b0;
    @(negedge clk_sys);
    chk({7'h0, flash_rst_b}, 8'h0);
    wait_flag(1'b0);
    chk({7'h0, rsp.aborted}, 8'h01);
  endtask : cut_after

  // Cut an erase inside its command sequence and a program while polled, then reissue both
  task automatic t_abort;
    op(fc_pkg::FC_OP_PROG, 17'h10000, 8'h22, 1'b0);
    issue(fc_pkg::FC_OP_CHIP_ERASE, 17'h0, 8'h0, 1'b0);
    cut_after(20);
    op(fc_pkg::FC_OP_CHIP_ERASE, 17'h0, 8'h0, 1'b0);
    chk({7'h0, rsp.aborted}, 8'h0);
    op(fc_pkg::FC_OP_READ, 17'h10000, 8'h0, 1'b0);
    chk(got, 8'hff);
    issue(fc_pkg::FC_OP_PROG, 17'h10001, 8'h0f, 1'b0);
    cut_after(24);
    op(fc_pkg::FC_OP_PROG, 17'h10001, 8'h0f, 1'b0);
    chk({7'h0, rsp.aborted}, 8'h0);
    op(fc_pkg::FC_OP_READ, 17'h10001, 8'h0, 1'b0);
    chk(got, 8'h0f);
  endtask : t_abort

  initial
  begin
    {mismatches, checks, n_wr} = '0;
    {rst_b, req_valid, abort_req, boot_override} = '0;
    req = '0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_program();
    t_sector();
    t_lockout();
    t_abort();
    test_done();
  end
endmodule : tb
